// file: verilog/pwm_time_base_pkg.sv
// Constants shared by the PWM time base control block and its helpers.
// Assumes a 16-bit register view placed in the low half of each 32-bit APB word.
package pwm_time_base_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned REG_W = 16;
  localparam int unsigned PS_W = 4;
  localparam int unsigned SRC_W = 3;

  // Register byte addresses, one aligned word each.
  localparam logic [ADDR_W-1:0] TIME_BASE_CONTROL_ADDR = 12'h000;
  localparam logic [ADDR_W-1:0] PRIMARY_PERIOD_ADDR = 12'h004;
  localparam logic [ADDR_W-1:0] SPECIAL_EVENT_COMPARE_ADDR = 12'h008;
  localparam logic [ADDR_W-1:0] MASTER_DUTY_CYCLE_ADDR = 12'h00C;
  localparam logic [ADDR_W-1:0] GENERATOR_CONTROL_ADDR = 12'h010;
  localparam logic [ADDR_W-1:0] PRIMARY_TIME_COUNT_ADDR = 12'h014;

  // Time base control fields.
  localparam int unsigned PWM_MODULE_ON_BIT = 15;
  localparam int unsigned IDLE_HALT_SELECT_BIT = 13;
  localparam int unsigned SPECIAL_EVENT_PENDING_BIT = 12;
  localparam int unsigned SPECIAL_EVENT_IRQ_ON_BIT = 11;
  localparam int unsigned IMMEDIATE_PERIOD_LOAD_BIT = 10;
  localparam int unsigned SYNC_IN_INVERT_BIT = 9;
  localparam int unsigned SYNC_OUT_ON_BIT = 8;
  localparam int unsigned EXTERNAL_SYNC_ON_BIT = 7;
  localparam int unsigned SYNC_SOURCE_LSB = 4;
  localparam int unsigned POSTSCALE_LSB = 0;
  localparam logic [SRC_W-1:0] SYNC_SOURCE_PIN = 3'h0;

  // Generator control fields.
  localparam int unsigned FAULT_PENDING_BIT = 15;
  localparam int unsigned CURRENT_LIMIT_PENDING_BIT = 14;
  localparam int unsigned TRIGGER_PENDING_BIT = 13;
  localparam int unsigned FAULT_IRQ_ON_BIT = 12;
  localparam int unsigned CURRENT_LIMIT_IRQ_ON_BIT = 11;
  localparam int unsigned TRIGGER_IRQ_ON_BIT = 10;
  localparam int unsigned OWN_TIME_BASE_SELECT_BIT = 9;
  localparam int unsigned SHARED_DUTY_SELECT_BIT = 8;

  // Writable masks; unimplemented bits read as zero.
  localparam logic [REG_W-1:0] TIME_BASE_CONTROL_MASK = 16'hBFFF;
  localparam logic [REG_W-1:0] COUNT_FIELD_MASK = 16'hFFF8;
  localparam logic [REG_W-1:0] GENERATOR_CONTROL_MASK = 16'hFFC3;
  localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
  localparam logic [REG_W-1:0] DUTY_MIN = 16'h0008;
  localparam logic [REG_W-1:0] DUTY_MAX = 16'hFFEF;
endpackage : pwm_time_base_pkg

// file: verilog/time_base_if.sv
// Connection between the control block and the primary time base counter.
// Assumes both ends share clk.
`timescale 1ns/1ps
`default_nettype none
interface time_base_if;
  logic on;
  logic run;
  logic syncReset;
  logic [15:0] period;
  logic [15:0] count;
  logic wrap;
  logic rollover;
  modport counter (input on, input run, input syncReset, input period, output count, output wrap, output rollover);
  modport control (output on, output run, output syncReset, output period, input count, input wrap, input rollover);
endinterface : time_base_if
`default_nettype wire

// file: verilog/primary_time_base.sv
// Primary time base: up counter from zero to the active period, then back to zero.
// Assumes the control block supplies enable, run and sync reset in the clk domain.
`timescale 1ns/1ps
`default_nettype none
module primary_time_base
  import pwm_time_base_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  time_base_if.counter tb
);
  typedef struct packed {
    logic [REG_W-1:0] count;
    logic rollover;
  } base_state_t;

  base_state_t state_q;
  base_state_t state_d;
  logic wrapNow;

  assign wrapNow = tb.on && tb.run && !tb.syncReset && (state_q.count >= tb.period);

  always_comb
  begin
    state_d = state_q;
    state_d.rollover = 1'b0;
    if (!tb.on)
    begin
      state_d.count = REG_RESET;
    end
    else if (tb.syncReset)
    begin
      state_d.count = REG_RESET;
    end
    else if (wrapNow)
    begin
      state_d.count = REG_RESET;
      state_d.rollover = 1'b1;
    end
    else if (tb.run)
    begin
      state_d.count = state_q.count + 16'h0001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign tb.count = state_q.count;
  assign tb.wrap = wrapNow;
  assign tb.rollover = state_q.rollover;

  property p_halt_holds;
    @(posedge clk) disable iff (srst)
      (tb.on && !tb.run && !tb.syncReset) |=> (tb.count == $past(tb.count));
  endproperty
  a_halt_holds: assert property (p_halt_holds) else $error("Time base moved while halted.");
endmodule : primary_time_base
`default_nettype wire

// file: verilog/event_postscaler.sv
// Postscaler for special events: one trigger pulse per (divide + 1) events.
// Assumes event pulses are one cycle wide and synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module event_postscaler
  import pwm_time_base_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic clear,
  input wire logic eventIn,
  input wire logic [PS_W-1:0] divide,
  output logic trigger
);
  typedef struct packed {
    logic [PS_W-1:0] count;
    logic trigger;
  } scale_state_t;

  scale_state_t state_q;
  scale_state_t state_d;

  always_comb
  begin
    state_d = state_q;
    state_d.trigger = 1'b0;
    if (clear)
    begin
      state_d.count = '0;
    end
    else if (eventIn)
    begin
      if (state_q.count >= divide)
      begin
        state_d.count = '0;
        state_d.trigger = 1'b1;
      end
      else
      begin
        state_d.count = state_q.count + 4'h1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign trigger = state_q.trigger;

  property p_every_event;
    @(posedge clk) disable iff (srst)
      (!clear && eventIn && divide == 4'h0) |=> trigger;
  endproperty
  a_every_event: assert property (p_every_event) else $error("Undivided event gave no trigger.");
endmodule : event_postscaler
`default_nettype wire

// file: verilog/pwm_time_base_control.sv
// PWM time base control: APB registers, primary time base, sync, special event and generator status.
// Assumes an APB master on clk; all pin inputs are synchronous to clk.
//
// Contract
// - Module enable bit runs the time base, postscaler and sync output; zero holds them disabled.
// - Idle-halt bit stops the time base while the CPU idles.
// - Special event pending bit is set when its interrupt becomes pending.
// - Special event request leaves only while its enable bit is one.
// - Immediate-load bit updates the active period at once, else at wrap.
// - Sync invert bit zero means sync input active high, one active low.
// - Sync output is driven only while sync output enable is one.
// - External sync enable lets the chosen sync source restart the time base.
// - Sync source code zero selects the pin; other codes are reserved.
// - Postscale field divides special event triggers by code plus one.
// - Period register holds bits fifteen to three; low three read zero.
// - Compare register holds bits fifteen to three; low three read zero.
// - Fault pending is set by fault events, cleared when its enable is zero.
// - Current-limit pending is set by events, cleared when its enable is zero.
// - Trigger pending is set by events, cleared when its enable is zero.
// - Fault enable zero suppresses fault requests and forces fault pending zero.
// - Shared duty select picks master duty, else the generator's own duty.
// - Own time base select takes period from phase value, else primary.
`timescale 1ns/1ps
`default_nettype none
module pwm_time_base_control
  import pwm_time_base_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpuIdle,
  input wire logic syncInputPin,
  input wire logic faultEvent,
  input wire logic currentLimitEvent,
  input wire logic triggerEvent,
  input wire logic [REG_W-1:0] generatorDuty,
  input wire logic [REG_W-1:0] phasePeriod,
  output logic moduleOn,
  output logic [REG_W-1:0] primaryTimeCount,
  output logic syncOutputPin,
  output logic specialEventTrigger,
  output logic specialEventIrq,
  output logic faultIrq,
  output logic currentLimitIrq,
  output logic triggerIrq,
  output logic [REG_W-1:0] selectedDuty,
  output logic [REG_W-1:0] generatorPeriod
);
  typedef struct packed {
    logic [REG_W-1:0] control;
    logic [REG_W-1:0] periodBuffer;
    logic [REG_W-1:0] activePeriod;
    logic [REG_W-1:0] compare;
    logic [REG_W-1:0] masterDuty;
    logic [REG_W-1:0] generator;
    logic [31:0] readData;
    logic syncPrev;
    logic syncOut;
    logic [REG_W-1:0] duty;
    logic [REG_W-1:0] genPeriod;
  } ctrl_state_t;

  ctrl_state_t state_q;
  ctrl_state_t state_d;
  time_base_if tb ();

  logic accessWrite;
  logic mapped;
  logic [REG_W-1:0] wdata;
  logic syncActive;
  logic syncReset;
  logic specialEvent;
  logic pwmModuleOn;

  function automatic logic known_address(input logic [ADDR_W-1:0] addr);
    known_address = (addr == TIME_BASE_CONTROL_ADDR) || (addr == PRIMARY_PERIOD_ADDR) ||
                    (addr == SPECIAL_EVENT_COMPARE_ADDR) || (addr == MASTER_DUTY_CYCLE_ADDR) ||
                    (addr == GENERATOR_CONTROL_ADDR) || (addr == PRIMARY_TIME_COUNT_ADDR);
  endfunction : known_address

  // Status bit update: software may only clear it by writing zero, a new event sets it and wins.
  function automatic logic status_next(input logic old, input logic written, input logic wbit,
                                       input logic setEvent, input logic enable);
    logic keep;
    keep = written ? (old & wbit) : old;
    status_next = enable & (keep | setEvent);
  endfunction : status_next

  assign mapped = known_address(paddr);
  assign accessWrite = psel && penable && pwrite && mapped;
  assign wdata = pwdata[REG_W-1:0];
  assign pwmModuleOn = state_q.control[PWM_MODULE_ON_BIT];

  // Zero-wait slave: read data is captured during the setup cycle.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = state_q.readData;

  assign syncActive = syncInputPin ^ state_q.control[SYNC_IN_INVERT_BIT];
  assign syncReset = state_q.control[EXTERNAL_SYNC_ON_BIT] &&
                     (state_q.control[SYNC_SOURCE_LSB +: SRC_W] == SYNC_SOURCE_PIN) &&
                     syncActive && !state_q.syncPrev;

  assign tb.on = pwmModuleOn;
  assign tb.run = pwmModuleOn && !(state_q.control[IDLE_HALT_SELECT_BIT] && cpuIdle);
  assign tb.syncReset = syncReset && pwmModuleOn;
  assign tb.period = state_q.activePeriod;

  assign specialEvent = tb.run && !tb.syncReset && (tb.count == state_q.compare);

  primary_time_base u_time_base (
    .clk(clk),
    .srst(srst),
    .tb(tb.counter)
  );

  event_postscaler u_postscaler (
    .clk(clk),
    .srst(srst),
    .clear(!pwmModuleOn),
    .eventIn(specialEvent),
    .divide(state_q.control[POSTSCALE_LSB +: PS_W]),
    .trigger(specialEventTrigger)
  );

  always_comb
  begin
    state_d = state_q;
    state_d.syncPrev = syncActive;
    state_d.syncOut = tb.rollover && state_q.control[SYNC_OUT_ON_BIT];
    if (accessWrite && paddr == TIME_BASE_CONTROL_ADDR)
    begin
      state_d.control = wdata & TIME_BASE_CONTROL_MASK;
    end
    state_d.control[SPECIAL_EVENT_PENDING_BIT] = status_next(state_q.control[SPECIAL_EVENT_PENDING_BIT],
        accessWrite && paddr == TIME_BASE_CONTROL_ADDR, wdata[SPECIAL_EVENT_PENDING_BIT],
        specialEventTrigger, 1'b1);
    if (accessWrite && paddr == PRIMARY_PERIOD_ADDR)
    begin
      state_d.periodBuffer = wdata & COUNT_FIELD_MASK;
    end
    if (accessWrite && paddr == PRIMARY_PERIOD_ADDR && state_q.control[IMMEDIATE_PERIOD_LOAD_BIT])
    begin
      state_d.activePeriod = wdata & COUNT_FIELD_MASK;
    end
    else if (tb.wrap || !pwmModuleOn)
    begin
      state_d.activePeriod = state_q.periodBuffer;
    end
    if (accessWrite && paddr == SPECIAL_EVENT_COMPARE_ADDR)
    begin
      state_d.compare = wdata & COUNT_FIELD_MASK;
    end
    if (accessWrite && paddr == MASTER_DUTY_CYCLE_ADDR)
    begin
      state_d.masterDuty = wdata;
    end
    if (accessWrite && paddr == GENERATOR_CONTROL_ADDR)
    begin
      state_d.generator = wdata & GENERATOR_CONTROL_MASK;
    end
    state_d.generator[FAULT_PENDING_BIT] = status_next(state_q.generator[FAULT_PENDING_BIT],
        accessWrite && paddr == GENERATOR_CONTROL_ADDR, wdata[FAULT_PENDING_BIT],
        faultEvent, state_d.generator[FAULT_IRQ_ON_BIT]);
    state_d.generator[CURRENT_LIMIT_PENDING_BIT] = status_next(state_q.generator[CURRENT_LIMIT_PENDING_BIT],
        accessWrite && paddr == GENERATOR_CONTROL_ADDR, wdata[CURRENT_LIMIT_PENDING_BIT],
        currentLimitEvent, state_d.generator[CURRENT_LIMIT_IRQ_ON_BIT]);
    state_d.generator[TRIGGER_PENDING_BIT] = status_next(state_q.generator[TRIGGER_PENDING_BIT],
        accessWrite && paddr == GENERATOR_CONTROL_ADDR, wdata[TRIGGER_PENDING_BIT],
        triggerEvent, state_d.generator[TRIGGER_IRQ_ON_BIT]);
    state_d.duty = state_q.generator[SHARED_DUTY_SELECT_BIT] ? state_q.masterDuty : generatorDuty;
    state_d.genPeriod = state_q.generator[OWN_TIME_BASE_SELECT_BIT] ? phasePeriod : state_q.activePeriod;
    if (psel && !penable)
    begin
      case (paddr)
        TIME_BASE_CONTROL_ADDR: state_d.readData = {16'h0000, state_q.control};
        PRIMARY_PERIOD_ADDR: state_d.readData = {16'h0000, state_q.periodBuffer};
        SPECIAL_EVENT_COMPARE_ADDR: state_d.readData = {16'h0000, state_q.compare};
        MASTER_DUTY_CYCLE_ADDR: state_d.readData = {16'h0000, state_q.masterDuty};
        GENERATOR_CONTROL_ADDR: state_d.readData = {16'h0000, state_q.generator};
        PRIMARY_TIME_COUNT_ADDR: state_d.readData = {16'h0000, tb.count};
        default: state_d.readData = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign moduleOn = pwmModuleOn;
  assign primaryTimeCount = tb.count;
  assign syncOutputPin = state_q.syncOut;
  assign specialEventIrq = state_q.control[SPECIAL_EVENT_PENDING_BIT] && state_q.control[SPECIAL_EVENT_IRQ_ON_BIT];
  assign faultIrq = state_q.generator[FAULT_PENDING_BIT] && state_q.generator[FAULT_IRQ_ON_BIT];
  assign currentLimitIrq = state_q.generator[CURRENT_LIMIT_PENDING_BIT] && state_q.generator[CURRENT_LIMIT_IRQ_ON_BIT];
  assign triggerIrq = state_q.generator[TRIGGER_PENDING_BIT] && state_q.generator[TRIGGER_IRQ_ON_BIT];
  assign selectedDuty = state_q.duty;
  assign generatorPeriod = state_q.genPeriod;

  property p_off_clears;
    @(posedge clk) disable iff (srst)
      !moduleOn |=> (primaryTimeCount == 16'h0000);
  endproperty
  a_off_clears: assert property (p_off_clears) else $error("Count not zero while disabled.");

  property p_pending_set;
    @(posedge clk) disable iff (srst)
      specialEventTrigger |=> state_q.control[SPECIAL_EVENT_PENDING_BIT];
  endproperty
  a_pending_set: assert property (p_pending_set) else $error("Special event trigger did not set pending.");

  property p_irq_gate;
    @(posedge clk) disable iff (srst)
      specialEventIrq |-> (state_q.control[SPECIAL_EVENT_IRQ_ON_BIT] && state_q.control[SPECIAL_EVENT_PENDING_BIT]);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("Special event request while disabled.");

  property p_immediate_load;
    @(posedge clk) disable iff (srst)
      (accessWrite && paddr == PRIMARY_PERIOD_ADDR && state_q.control[IMMEDIATE_PERIOD_LOAD_BIT])
        |=> (state_q.activePeriod == ($past(pwdata[REG_W-1:0]) & COUNT_FIELD_MASK));
  endproperty
  a_immediate_load: assert property (p_immediate_load) else $error("Immediate period load missed.");

  property p_deferred_load;
    @(posedge clk) disable iff (srst)
      (moduleOn && !tb.wrap && !(accessWrite && paddr == PRIMARY_PERIOD_ADDR))
        |=> (state_q.activePeriod == $past(state_q.activePeriod));
  endproperty
  a_deferred_load: assert property (p_deferred_load) else $error("Active period changed off boundary.");

  property p_sync_out;
    @(posedge clk) disable iff (srst)
      syncOutputPin |-> ($past(state_q.control[SYNC_OUT_ON_BIT]) && $past(tb.rollover));
  endproperty
  a_sync_out: assert property (p_sync_out) else $error("Sync output while disabled.");

  property p_sync_restart;
    @(posedge clk) disable iff (srst)
      (moduleOn && syncReset) |=> (primaryTimeCount == 16'h0000);
  endproperty
  a_sync_restart: assert property (p_sync_restart) else $error("Sync did not restart time base.");

  property p_period_low_zero;
    @(posedge clk) disable iff (srst)
      (psel && !penable && (paddr == PRIMARY_PERIOD_ADDR || paddr == SPECIAL_EVENT_COMPARE_ADDR))
        |=> (prdata[2:0] == 3'h0);
  endproperty
  a_period_low_zero: assert property (p_period_low_zero) else $error("Low count bits read nonzero.");

  property p_fault_forced;
    @(posedge clk) disable iff (srst)
      !state_q.generator[FAULT_IRQ_ON_BIT] |-> (!state_q.generator[FAULT_PENDING_BIT] && !faultIrq);
  endproperty
  a_fault_forced: assert property (p_fault_forced) else $error("Fault pending while disabled.");

  property p_fault_set;
    @(posedge clk) disable iff (srst)
      (faultEvent && state_d.generator[FAULT_IRQ_ON_BIT]) |=> state_q.generator[FAULT_PENDING_BIT];
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("Fault event lost.");

  property p_duty_select;
    @(posedge clk) disable iff (srst)
      state_q.generator[SHARED_DUTY_SELECT_BIT] ##1 state_q.generator[SHARED_DUTY_SELECT_BIT]
        |-> (selectedDuty == $past(state_q.masterDuty));
  endproperty
  a_duty_select: assert property (p_duty_select) else $error("Shared duty not selected.");

  property p_wrap_restart;
    @(posedge clk) disable iff (srst)
      tb.wrap |=> (primaryTimeCount == 16'h0000 && tb.rollover);
  endproperty
  a_wrap_restart: assert property (p_wrap_restart) else $error("Time base did not restart at period.");

  property p_compare_event;
    @(posedge clk) disable iff (srst)
      (moduleOn && tb.run && !syncReset && primaryTimeCount == state_q.compare) |-> specialEvent;
  endproperty
  a_compare_event: assert property (p_compare_event) else $error("Compare match gave no event.");

  property p_source_reserved;
    @(posedge clk) disable iff (srst)
      (state_q.control[SYNC_SOURCE_LSB +: SRC_W] != SYNC_SOURCE_PIN) |-> !tb.syncReset;
  endproperty
  a_source_reserved: assert property (p_source_reserved) else $error("Reserved source gave sync.");

  property p_sync_off;
    @(posedge clk) disable iff (srst)
      !state_q.control[EXTERNAL_SYNC_ON_BIT] |-> !tb.syncReset;
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("Sync while external sync off.");

  property p_limit_forced;
    @(posedge clk) disable iff (srst)
      !state_q.generator[CURRENT_LIMIT_IRQ_ON_BIT] |-> !state_q.generator[CURRENT_LIMIT_PENDING_BIT];
  endproperty
  a_limit_forced: assert property (p_limit_forced) else $error("Limit pending while disabled.");

  property p_trigger_forced;
    @(posedge clk) disable iff (srst)
      !state_q.generator[TRIGGER_IRQ_ON_BIT] |-> !state_q.generator[TRIGGER_PENDING_BIT];
  endproperty
  a_trigger_forced: assert property (p_trigger_forced) else $error("Trigger pending while disabled.");

  // The select bit must stand two cycles because the period output lags it by one.
  property p_own_period;
    @(posedge clk) disable iff (srst)
      state_q.generator[OWN_TIME_BASE_SELECT_BIT] ##1 state_q.generator[OWN_TIME_BASE_SELECT_BIT]
        |-> (generatorPeriod == $past(phasePeriod));
  endproperty
  a_own_period: assert property (p_own_period) else $error("Own period not selected.");

  c_sync_restart: cover property (@(posedge clk) disable iff (srst) moduleOn && syncReset);
  c_idle_halt: cover property (@(posedge clk) disable iff (srst) moduleOn && !tb.run);
  c_fault_request: cover property (@(posedge clk) disable iff (srst) faultIrq && currentLimitIrq);
  c_special_trigger: cover property (@(posedge clk) disable iff (srst) specialEventTrigger && specialEventIrq);
  c_deferred_wrap: cover property (@(posedge clk) disable iff (srst)
    tb.wrap && !state_q.control[IMMEDIATE_PERIOD_LOAD_BIT] && state_q.activePeriod != state_q.periodBuffer);
endmodule : pwm_time_base_control
`default_nettype wire

// file: dv/pwm_far_side.sv
// Far-side model: external sync source and converter event sources.
// Assumes requests arrive from the bench just after rising clk edges.
`timescale 1ns/1ps
`default_nettype none
module pwm_far_side
(
  input wire logic clk,
  input wire logic activeLow,
  input wire logic syncReq,
  input wire logic [2:0] evReq,
  output logic syncPin,
  output logic [2:0] events
);
  logic [1:0] pulseQ = 2'h0;
  logic [2:0] eventQ = 3'h0;
  // The pin rests at its inactive level and shows the active level for two cycles.
  always @(posedge clk)
  begin
    pulseQ <= {pulseQ[0], syncReq};
    eventQ <= evReq;
  end
  assign syncPin = activeLow ^ (|pulseQ);
  assign events = eventQ;
endmodule : pwm_far_side
`default_nettype wire

// file: dv/power_pwm_time_base_control_tb.sv
// Self-checking bench for the PWM time base control block.
// Assumes the design package and the far-side model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module power_pwm_time_base_control_tb
  import pwm_time_base_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic cpuIdle = 1'b0;
  logic syncLow = 1'b0;
  logic syncReq = 1'b0;
  logic [2:0] evReq = '0;
  logic [REG_W-1:0] genDuty = 16'h0100;
  logic [REG_W-1:0] phasePer = 16'h0200;
  logic [31:0] prdata;
  logic pready, pslverr, syncPin, moduleOn, seTrig, seIrq, fIrq, clIrq, tIrq, syncOut;
  logic [2:0] ev;
  logic [REG_W-1:0] count, selDuty, genPer;
  int mismatches = 0;
  int total_checks = 0;
  int trigs, syncs, cmax, c0, i;
  int model [6];
  int ps [8] = '{0, 1, 2, 3, 5, 7, 11, 15};
  logic [31:0] rnd = 32'h269D;
  logic [31:0] rd;
  logic err;
  always #2.5 clk = ~clk;
  pwm_time_base_control i_pwm_time_base_control (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpuIdle(cpuIdle), .syncInputPin(syncPin), .faultEvent(ev[2]), .currentLimitEvent(ev[1]),
    .triggerEvent(ev[0]), .generatorDuty(genDuty), .phasePeriod(phasePer), .moduleOn(moduleOn),
    .primaryTimeCount(count), .syncOutputPin(syncOut), .specialEventTrigger(seTrig),
    .specialEventIrq(seIrq), .faultIrq(fIrq), .currentLimitIrq(clIrq), .triggerIrq(tIrq),
    .selectedDuty(selDuty), .generatorPeriod(genPer));
  pwm_far_side i_pwm_far_side (.clk(clk), .activeLow(syncLow), .syncReq(syncReq), .evReq(evReq),
    .syncPin(syncPin), .events(ev));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  // Entered just after a rising edge; the upper data half is junk that must be ignored.
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [15:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'hA5A5, d};
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1)
    begin
      mismatches++;
      finish_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rdc(input string n, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 16'h0000);
    chk(n, rd, exp);
  endtask : rdc
  task automatic watch(input int cyc);
    trigs = 0;
    syncs = 0;
    repeat (cyc)
    begin
      @(posedge clk);
      trigs += int'(seTrig !== 1'b0);
      syncs += int'(syncOut !== 1'b0);
    end
  endtask : watch
  // Tracks the highest count until the time base is back at zero.
  task automatic pmax;
    int n;
    n = 0;
    cmax = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (count > cmax)
        cmax = count;
    end
    while (count !== 16'h0000 && n < 300);
    if (n == 300)
    begin
      mismatches++;
      finish_test();
    end
  endtask : pmax
  initial
  begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 6; i++)
      rdc("reset value", 12'(4 * i), 32'h0);
    rdc("unmapped data", 12'h018, 32'h0);
    chk("unmapped error", err, 1'b1);
    for (i = 1; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      model[i] = (i == 3) ? 8 + rnd % 16'hFFE8 : rnd[15:0] & COUNT_FIELD_MASK;
      apb(1'b1, 12'(4 * i), rnd[15:0] & ((i == 3) ? 16'h0 : 16'hFFFF) | 16'(model[i]));
      rdc("stored value", 12'(4 * i), model[i]);
    end
    apb(1'b1, PRIMARY_PERIOD_ADDR, 16'h0010);
    apb(1'b1, SPECIAL_EVENT_COMPARE_ADDR, 16'h0008);
    $display("test registers done");
    foreach (ps[k])
    begin
      apb(1'b1, TIME_BASE_CONTROL_ADDR, 16'h0100 | 16'(ps[k]));
      apb(1'b1, TIME_BASE_CONTROL_ADDR, 16'h8100 | 16'(ps[k]));
      watch(816);
      chk("postscaled triggers", trigs, 48 / (ps[k] + 1));
      chk("sync out pulses", syncs >= 47 && syncs <= 48, 1);
      chk("module on", moduleOn, 1'b1);
    end
    rdc("event pending", TIME_BASE_CONTROL_ADDR, 32'h810F | 32'h1000);
    chk("masked request", seIrq, 1'b0);
    apb(1'b1, TIME_BASE_CONTROL_ADDR, 16'h980F);
    chk("enabled request", seIrq, 1'b1);
    apb(1'b1, TIME_BASE_CONTROL_ADDR, 16'h0000);
    watch(40);
    chk("off count", count, 16'h0000);
    chk("off triggers", trigs + syncs, 0);
    chk("off request", seIrq, 1'b0);
    $display("test special event done");
    apb(1'b1, TIME_BASE_CONTROL_ADDR, 16'hA000);
    cpuIdle <= 1'b1;
    watch(2);
    c0 = count;
    watch(30);
    chk("halted in idle", count, 16'(c0));
    apb(1'b1, TIME_BASE_CONTROL_ADDR, 16'h8000);
    c0 = count;
    watch(3);
    chk("runs in idle", count !== 16'(c0), 1'b1);
    chk("sync out off", syncs, 0);
    cpuIdle <= 1'b0;
    $display("test idle done");
    pmax();
    apb(1'b1, PRIMARY_PERIOD_ADDR, 16'h0040);
    pmax();
    chk("deferred period", cmax, 16);
    pmax();
    chk("new period", cmax, 64);
    apb(1'b1, TIME_BASE_CONTROL_ADDR, 16'h8400);
    apb(1'b1, PRIMARY_PERIOD_ADDR, 16'h0010);
    pmax();
    chk("immediate period", cmax, 16);
    apb(1'b1, PRIMARY_PERIOD_ADDR, 16'h0040);
    model[1] = 16'h0040;
    $display("test period done");
    for (i = 0; i < 3; i++)
    begin
      apb(1'b1, TIME_BASE_CONTROL_ADDR, 16'h8400 | 16'(i < 2) << 7 | 16'(i == 1) << 9);
      syncLow <= (i == 1);
      pmax();
      repeat (20) @(posedge clk);
      syncReq <= 1'b1;
      @(posedge clk);
      syncReq <= 1'b0;
      repeat (4) @(posedge clk);
      chk("sync restart", count < 6, i < 2);
    end
    $display("test sync done");
    rnd = lfsr(rnd);
    genDuty <= rnd[15:0];
    phasePer <= rnd[31:16];
    apb(1'b1, GENERATOR_CONTROL_ADDR, 16'h1F00);
    evReq <= 3'b111;
    @(posedge clk);
    evReq <= 3'b000;
    repeat (3) @(posedge clk);
    rdc("generator pending", GENERATOR_CONTROL_ADDR, 32'hFF00);
    chk("generator requests", {fIrq, clIrq, tIrq}, 3'b111);
    chk("shared duty", selDuty, 16'(model[3]));
    chk("own period", genPer, rnd[31:16]);
    apb(1'b1, GENERATOR_CONTROL_ADDR, 16'h03FF);
    evReq <= 3'b111;
    @(posedge clk);
    evReq <= 3'b000;
    repeat (3) @(posedge clk);
    rdc("pending cleared", GENERATOR_CONTROL_ADDR, 32'h03C3);
    chk("requests off", {fIrq, clIrq, tIrq}, 3'b000);
    apb(1'b1, GENERATOR_CONTROL_ADDR, 16'h0003);
    repeat (2) @(posedge clk);
    chk("own duty", selDuty, rnd[15:0]);
    chk("primary period", genPer, 16'(model[1]));
    $display("test generator done");
    finish_test();
  end
endmodule : power_pwm_time_base_control_tb
`default_nettype wire
